// File: hw/adcrc_top.sv
`timescale 1ns/1ns
module adcrc_top (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Register bus
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic        SFR_WR,
  input  wire logic        SFR_RD,
  input  wire logic [7:0]  SFR_WDATA,
  output      logic [7:0]  SFR_RDATA,
  // Analog converter
  output      logic        CONV_START,
  output      logic        CONV_ABORT,
  input  wire logic        CONV_DONE,
  input  wire logic [11:0] CONV_DATA,
  // Analog configuration
  output      logic        ANALOG_POWER,
  output      logic        ANALOG_PINS_EN,
  output      logic [3:0]  CHANNEL_SEL,
  output      logic [1:0]  REF_SEL,
  output      logic [1:0]  INPUT_MODE,
  output      logic        CONTINUOUS,
  output      logic [2:0]  RATE_SEL,
  output      logic [1:0]  ACQ_SEL,
  output      logic [1:0]  RESOLUTION,
  output      logic        CONV_DONE_IRQ
);
  logic [7:0]  chan_q;
  logic [7:0]  mode_q;
  logic [7:0]  rstat_q;
  logic [7:0]  hi_q;
  logic [7:0]  lo_q;
  logic        done_q;
  logic        start_q;
  logic        busy;
  logic [15:0] just;
  adcrc_conv_if conv ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  //----------------------------------------
  // Decode
  //----------------------------------------
  wire wr_chan  = SFR_WR && hit(SFR_ADDR, adcrc_pkg::ADDR_CHAN_PWR);
  wire wr_mode  = SFR_WR && hit(SFR_ADDR, adcrc_pkg::ADDR_MODE);
  wire wr_rstat = SFR_WR && hit(SFR_ADDR, adcrc_pkg::ADDR_RES_STAT);
  wire pwr      = chan_q[adcrc_pkg::PWR_BIT];
  wire new_pwr  = SFR_WDATA[adcrc_pkg::PWR_BIT];
  // Writes only to channel/power start a conversion
  wire start    = wr_chan && new_pwr; // R18
  wire [1:0]  resol = rstat_q[adcrc_pkg::RESOL_LSB +: 2];
  wire [11:0] d     = conv.data;
  wire [3:0]  nbits = adcrc_pkg::MIN_BITS + {resol, 1'b0}; // R17
  wire [11:0] vmask = 12'hFFF >> (adcrc_pkg::MAX_BITS - nbits);
  wire [11:0] dv    = d & vmask;
  wire        uflow = (dv == 12'h000); // R10
  wire        oflow = (dv == vmask); // R11

  //----------------------------------------
  // Justification
  //----------------------------------------
  always_comb
  begin
    if (rstat_q[adcrc_pkg::RLJUST_BIT]) // R9
      just = {4'h0, dv}; // R14
    else
      just = {dv, 4'h0} << (adcrc_pkg::MAX_BITS - nbits); // R14
  end

  //----------------------------------------
  // Registers
  //----------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      chan_q  <= adcrc_pkg::RESET_VALUE; // R15
      mode_q  <= adcrc_pkg::RESET_VALUE;
      rstat_q <= adcrc_pkg::RESET_VALUE;
      hi_q    <= adcrc_pkg::RESET_VALUE;
      lo_q    <= adcrc_pkg::RESET_VALUE;
      done_q  <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      if (wr_chan)
        chan_q <= SFR_WDATA & adcrc_pkg::CHAN_PWR_WMASK; // R20
      if (wr_mode)
        mode_q <= SFR_WDATA;
      if (wr_rstat)
        rstat_q <= (SFR_WDATA & adcrc_pkg::RES_STAT_WMASK) |
                   (rstat_q & ~adcrc_pkg::RES_STAT_WMASK); // R20
      if (conv.done && !start)
      begin
        hi_q <= just[15:8]; // R13
        lo_q <= just[7:0]; // R13
        rstat_q[adcrc_pkg::UFLOW_BIT] <= uflow;
        rstat_q[adcrc_pkg::OFLOW_BIT] <= oflow;
        rstat_q[adcrc_pkg::RANGE_BIT] <= uflow | oflow; // R12
      end
      done_q  <= conv.done && !start; // R19
      start_q <= start;
    end
  end

  //----------------------------------------
  // Busy flag
  //----------------------------------------
  adcrc_busy_timer #(
    .DELAY (adcrc_pkg::BUSY_DELAY_CYC)
  ) u_busy (
    .CLOCK (CLOCK),
    .RST   (RST),
    .start (start),
    .clear (done_q || (wr_chan && !new_pwr)), // R2
    .busy  (busy)
  );

  assign conv.start = start_q;
  assign conv.abort = start_q; // R18
  assign conv.done  = CONV_DONE;
  assign conv.data  = CONV_DATA;

  //----------------------------------------
  // Read mux
  //----------------------------------------
  always_comb
  begin
    SFR_RDATA = 8'h00;
    if (SFR_RD)
    begin
      case (SFR_ADDR)
        adcrc_pkg::ADDR_CHAN_PWR: SFR_RDATA = chan_q | (8'(busy) << adcrc_pkg::BUSY_BIT); // R2
        adcrc_pkg::ADDR_MODE:     SFR_RDATA = mode_q;
        adcrc_pkg::ADDR_RES_STAT: SFR_RDATA = rstat_q & adcrc_pkg::RES_STAT_RMASK; // R20
        adcrc_pkg::ADDR_RES_HIGH: SFR_RDATA = hi_q;
        adcrc_pkg::ADDR_RES_LOW:  SFR_RDATA = lo_q;
        default:                  SFR_RDATA = 8'h00;
      endcase
    end
  end

  //----------------------------------------
  // Outputs
  //----------------------------------------
  assign CONV_START     = conv.start;
  assign CONV_ABORT     = conv.abort;
  assign ANALOG_POWER   = pwr; // R1
  assign ANALOG_PINS_EN = pwr; // R1
  assign CHANNEL_SEL    = chan_q[adcrc_pkg::CHAN_LSB +: 4]; // R16
  assign REF_SEL        = chan_q[adcrc_pkg::REF_LSB +: 2]; // R3
  assign INPUT_MODE     = mode_q[adcrc_pkg::DIFF_LSB +: 2]; // R4
  assign CONTINUOUS     = mode_q[adcrc_pkg::CONT_BIT]; // R5
  assign RATE_SEL       = mode_q[adcrc_pkg::RATE_LSB +: 3]; // R6 R7
  assign ACQ_SEL        = mode_q[adcrc_pkg::ACQ_LSB +: 2]; // R8
  assign RESOLUTION     = resol; // R17
  assign CONV_DONE_IRQ  = done_q;
endmodule : adcrc_top

// File: include/adcrc_pkg.sv
// Overview of operation
// R1 - Power bit 7 switches converter on or off
// R2 - Busy bit 6 high during conversion
// R3 - Reference field 1:0 selects four sources
// R4 - Input mode field 7:6 selects differential
// R5 - Continuous bit 5 selects repeated conversions
// R6 - Rate field sets 2 to 16 ksps
// R7 - Rate field sets single-step power-down delay
// R8 - Acquisition field sets window 0.75 to 36us
// R9 - Justify bit 5: left 0, right 1
// R10 - Underflow bit 4 set on all zeroes
// R11 - Overflow bit 3 set on all ones
// R12 - Range bit 2 is overflow OR underflow
// R13 - Result bytes return justified high, low
// R14 - Justify aligns result, zero-fills the rest
// R15 - All five registers reset to zero
// R16 - Channel field 5:2 selects sixteen inputs
// R17 - Resolution field selects 6 to 12 bits
// R18 - Channel/power write starts conversion when powered
// R19 - Busy rises four 16 MHz cycles later
// R20 - Unused and read-only bits ignore writes
package adcrc_pkg;
  localparam logic [7:0] ADDR_RES_STAT = 8'hD1;
  localparam logic [7:0] ADDR_MODE     = 8'hD2;
  localparam logic [7:0] ADDR_CHAN_PWR = 8'hD3;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hD4;
  localparam logic [7:0] ADDR_RES_LOW  = 8'hD5;
  localparam logic [7:0] RESET_VALUE   = 8'h00;
  localparam int PWR_BIT    = 7;
  localparam int BUSY_BIT   = 6;
  localparam int CONT_BIT   = 5;
  localparam int RLJUST_BIT = 5;
  localparam int UFLOW_BIT  = 4;
  localparam int OFLOW_BIT  = 3;
  localparam int RANGE_BIT  = 2;
  localparam logic [7:0] CHAN_PWR_WMASK = 8'hBF;
  localparam logic [7:0] RES_STAT_WMASK = 8'hE0;
  localparam logic [7:0] RES_STAT_RMASK = 8'hFC;
  localparam int CHAN_LSB  = 2;
  localparam int REF_LSB   = 0;
  localparam int DIFF_LSB  = 6;
  localparam int RATE_LSB  = 2;
  localparam int ACQ_LSB   = 0;
  localparam int RESOL_LSB = 6;
  localparam logic [3:0] MIN_BITS = 4'h6;
  localparam logic [3:0] MAX_BITS = 4'hC;
  localparam int CLK_MHZ      = 250;
  localparam int SLOW_CLK_MHZ = 16;
  // Busy delay: four cycles of the 16 MHz converter clock, rounded up
  localparam int BUSY_SLOW_CYCLES = 4;
  localparam int BUSY_DELAY_CYC =
    (BUSY_SLOW_CYCLES * CLK_MHZ + SLOW_CLK_MHZ - 1) / SLOW_CLK_MHZ;
  localparam logic [1:0] RATE_2K   = 2'h0;
  localparam logic [1:0] DIFF_NONE = 2'h0;
  localparam logic [1:0] DIFF_PIN2 = 2'h1;
  localparam logic [1:0] DIFF_PIN6 = 2'h2;
  localparam logic [2:0] PD_NEVER  = 3'h3;
endpackage : adcrc_pkg

// File: include/adcrc_conv_if.sv
`timescale 1ns/1ns
interface adcrc_conv_if;
  logic        start;
  logic        abort;
  logic        done;
  logic [11:0] data;
  modport ctrl (output start, output abort, input done, input data);
  modport seq  (input start, input abort, output done, output data);
endinterface : adcrc_conv_if

// File: hw/adcrc_busy_timer.sv
`timescale 1ns/1ns
module adcrc_busy_timer #(
  parameter int DELAY = adcrc_pkg::BUSY_DELAY_CYC
) (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // Conversion
  input  wire logic start,
  input  wire logic clear,
  output      logic busy
);
  localparam int W = $clog2(DELAY + 1);
  logic [W-1:0] cnt_q;
  logic         pend_q;
  logic         busy_q;
  wire          fire = pend_q && (cnt_q == W'(DELAY - 1));

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      cnt_q  <= '0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
    end
    // A new start outranks the clear left by the previous result
    else if (start)
    begin
      cnt_q  <= '0;
      pend_q <= 1'b1;
      busy_q <= 1'b0;
    end
    else if (clear)
    begin
      cnt_q  <= '0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else if (pend_q)
    begin
      cnt_q  <= cnt_q + W'(1);
      pend_q <= !fire;
      busy_q <= busy_q | fire; // R19
    end
  end
  assign busy = busy_q;
endmodule : adcrc_busy_timer

// File: bench/adcrc_chk.sv
`timescale 1ns/1ns
module adcrc_chk (
  // Clock, reset and register bus
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  // Converter and configuration
  input wire logic       CONV_START,
  input wire logic       CONV_DONE,
  input wire logic       CONV_DONE_IRQ,
  input wire logic       ANALOG_POWER,
  input wire logic [3:0] CHANNEL_SEL,
  input wire logic [1:0] REF_SEL,
  input wire logic [1:0] INPUT_MODE,
  input wire logic       CONTINUOUS,
  input wire logic [2:0] RATE_SEL,
  input wire logic [1:0] ACQ_SEL,
  input wire logic       CONV_ABORT,
  input wire logic       ANALOG_PINS_EN,
  input wire logic [1:0] RESOLUTION
);
  wire logic wr3 = SFR_WR && SFR_ADDR == 8'hD3;
  wire logic rd1 = SFR_RD && SFR_ADDR == 8'hD1;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_start_write: assert property (wr3 && SFR_WDATA[7] |=> CONV_START)
    else $error("no start after powered write");
  a_no_start: assert property (!(wr3 && SFR_WDATA[7]) |=> !CONV_START)
    else $error("start without powered write");
  a_power_bit: assert property (wr3 |=> ANALOG_POWER == $past(SFR_WDATA[7]))
    else $error("power output wrong");
  a_chan_ref: assert property (wr3 |=> {CHANNEL_SEL, REF_SEL} == $past(SFR_WDATA[5:0]))
    else $error("channel or reference wrong");
  a_mode_fields: assert property (SFR_WR && SFR_ADDR == 8'hD2 |=>
    {INPUT_MODE, CONTINUOUS, RATE_SEL, ACQ_SEL} == $past(SFR_WDATA))
    else $error("mode fields wrong");
  a_range_or: assert property (rd1 |-> SFR_RDATA[2] == (SFR_RDATA[3] | SFR_RDATA[4]))
    else $error("range flag wrong");
  a_unused_zero: assert property (rd1 |-> SFR_RDATA[1:0] == 2'h0)
    else $error("unused bits not zero");
  a_unmapped_zero: assert property (SFR_RD && (SFR_ADDR < 8'hD1 || SFR_ADDR > 8'hD5)
    |-> SFR_RDATA == 8'h00) else $error("unmapped read not zero");
  a_irq_done: assert property (CONV_DONE_IRQ |-> $past(CONV_DONE))
    else $error("interrupt without result");
  a_pins_power: assert property (wr3 |=> ANALOG_PINS_EN == $past(SFR_WDATA[7]))
    else $error("analog pin enable wrong");
  a_abort_start: assert property (wr3 && SFR_WDATA[7] |=> CONV_ABORT)
    else $error("no abort after powered write");
  a_resol_field: assert property (SFR_WR && SFR_ADDR == 8'hD1 |=>
    RESOLUTION == $past(SFR_WDATA[7:6]))
    else $error("resolution field wrong");
  cover property (CONV_DONE_IRQ);
  cover property (wr3 && SFR_WDATA[7]);
  cover property (rd1 && SFR_RDATA[2]);
endmodule : adcrc_chk
bind adcrc_top adcrc_chk u_chk (.CLOCK, .RST, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA,
  .SFR_RDATA, .CONV_START, .CONV_DONE, .CONV_DONE_IRQ, .ANALOG_POWER, .CHANNEL_SEL,
  .REF_SEL, .INPUT_MODE, .CONTINUOUS, .RATE_SEL, .ACQ_SEL, .CONV_ABORT, .ANALOG_PINS_EN,
  .RESOLUTION);

// File: bench/adcrc_conv_model.sv
`timescale 1ns/1ns
module adcrc_conv_model #(parameter int LAT = 100) (
  // Converter side
  input  wire logic        CLOCK,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [11:0] value,
  output      logic        done = 1'h0,
  output      logic [11:0] data
);
  int cnt = 0;
  // Restart on start, drop on abort, result pulse when the count ends
  always @(posedge CLOCK)
  begin
    done <= cnt == 1;
    cnt <= start ? LAT : abort ? 0 : cnt > 0 ? cnt - 1 : 0;
  end
  assign data = done ? value : ~value;
endmodule : adcrc_conv_model

// File: bench/tb.sv
`timescale 1ns/1ns
module tb;
  logic CLOCK = 0, RST = 1, SFR_WR = 0, SFR_RD = 0, CONV_DONE, CONV_START, CONV_ABORT;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
  logic [11:0] CONV_DATA, value = 12'h000;
  logic ANALOG_POWER, ANALOG_PINS_EN, CONTINUOUS, CONV_DONE_IRQ;
  logic [3:0] CHANNEL_SEL;
  logic [1:0] REF_SEL, INPUT_MODE, ACQ_SEL, RESOLUTION;
  logic [2:0] RATE_SEL;
  int n_mismatch = 0, comparisons = 0;
  adcrc_top DUT (.CLOCK, .RST, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA,
    .CONV_START, .CONV_ABORT, .CONV_DONE, .CONV_DATA, .ANALOG_POWER, .ANALOG_PINS_EN,
    .CHANNEL_SEL, .REF_SEL, .INPUT_MODE, .CONTINUOUS, .RATE_SEL, .ACQ_SEL, .RESOLUTION,
    .CONV_DONE_IRQ);
  adcrc_conv_model u_conv (.CLOCK, .start(CONV_START), .abort(CONV_ABORT), .value,
    .done(CONV_DONE), .data(CONV_DATA));
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1;
    @(negedge CLOCK);
    SFR_WR = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge CLOCK);
    SFR_ADDR = a;
    SFR_RD = 1;
    #1;
    comparisons++;
    if (SFR_RDATA !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, SFR_RDATA, exp);
    end
    @(negedge CLOCK);
    SFR_RD = 0;
  endtask : rd
  initial forever #2 CLOCK = ~CLOCK;
  initial
  begin
    int n, i;
    logic [15:0] d, e;
    logic uf, of;
    repeat (10) @(negedge CLOCK);
    RST = 0;
    for (int a = 8'hD1; a <= 8'hD5; a++) rd(a[7:0], 8'h00);
    rd(8'hD0, 8'h00);
    wr(8'hD2, 8'hFF);
    rd(8'hD2, 8'hFF);
    wr(8'hD4, 8'h55);
    rd(8'hD4, 8'h00);
    wr(8'hD1, 8'hFF);
    rd(8'hD1, 8'hE0);
    wr(8'hD3, 8'h7F);
    rd(8'hD3, 8'h3F);
    for (int k = 0; k < 8; k++)
    begin
      n = 6 + 2 * (k % 4);
      value = (k % 3 == 0) ? 12'h000 : (k % 3 == 1) ? 12'hFFF : 12'hA5C;
      d = {4'h0, value} & ((16'h1 << n) - 16'h1);
      e = (k >= 4) ? d : d << (16 - n);
      uf = d == 16'h0;
      of = d == (16'h1 << n) - 16'h1;
      wr(8'hD1, {k[1:0], k[2], 5'h00});
      wr(8'hD3, {2'h2, k[3:0], k[1:0]});
      repeat (58) @(negedge CLOCK);
      rd(8'hD3, {2'h2, k[3:0], k[1:0]});
      repeat (10) @(negedge CLOCK);
      rd(8'hD3, {2'h3, k[3:0], k[1:0]});
      for (i = 0; i < 300 && CONV_DONE_IRQ !== 1'h1; i++) @(negedge CLOCK);
      if (i == 300)
      begin
        n_mismatch++;
        test_done();
      end
      rd(8'hD4, e[15:8]);
      rd(8'hD5, e[7:0]);
      rd(8'hD1, {k[1:0], k[2], uf, of, uf | of, 2'h0});
      rd(8'hD3, {2'h2, k[3:0], k[1:0]});
    end
    RST = 1;
    repeat (2) @(negedge CLOCK);
    RST = 0;
    for (int a = 8'hD1; a <= 8'hD5; a++) rd(a[7:0], adcrc_pkg::RESET_VALUE);
    wr(8'hD3, 8'h80);
    repeat (70) @(negedge CLOCK);
    rd(8'hD3, 8'hC0);
    wr(8'hD3, 8'h80);
    rd(8'hD3, 8'h80);
    wr(8'hD3, 8'h00);
    rd(8'hD3, 8'h00);
    test_done();
  end
endmodule : tb
